// *** core/fws_pkg.sv ***
package fws_pkg;
  // ==========================================================
  // widths and timing
  localparam int AW = 17;
  localparam int DW = 8;
  localparam int CW = 2;
  localparam int CLK_MHZ = 25;
  localparam int T_CLK_NS = 1000 / CLK_MHZ;
  localparam int T_WP_NS = 35;
  localparam int T_ACC_NS = 70;
  localparam int WP_CYC = (T_WP_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + T_CLK_NS - 1) / T_CLK_NS;
  // ==========================================================
  // status bit positions on the data bus
  localparam int BIT_POLL = 7;
  localparam int BIT_TOG = 6;
  localparam int BIT_FAIL = 5;
  localparam int BIT_WIN = 3;
  localparam int BIT_STOG = 2;
  // ==========================================================
  // command addresses and codes
  localparam logic [AW-1:0] ADDR_UNLOCK1 = 17'h0_5555;
  localparam logic [AW-1:0] ADDR_UNLOCK2 = 17'h0_2aaa;
  localparam logic [DW-1:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [DW-1:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [DW-1:0] CMD_PROG = 8'ha0;
  localparam logic [DW-1:0] CMD_ERASE = 8'h80;
  localparam logic [DW-1:0] CMD_SECT = 8'h30;
  localparam logic [DW-1:0] CMD_CHIP = 8'h10;
  localparam logic [DW-1:0] CMD_SUSPEND = 8'hb0;
  localparam logic [DW-1:0] CMD_RESUME = 8'h30;
  localparam logic [DW-1:0] CMD_RESET = 8'hf0;
  // sequence lengths in bus writes
  localparam logic [2:0] SEQ_LEN_PROG = 3'h4;
  localparam logic [2:0] SEQ_LEN_ERASE = 3'h6;
  localparam logic [2:0] SEQ_LEN_ONE = 3'h1;
  // ==========================================================
  // user operations and answers
  typedef enum logic [3:0] {
    OP_READ, OP_PROG, OP_SECT, OP_ADD, OP_CHIP,
    OP_WAIT, OP_SUSPEND, OP_RESUME, OP_RESET
  } fws_op_e;
  typedef enum logic [1:0] {RSP_OK, RSP_FAIL, RSP_REJECT} fws_rsp_e;
endpackage : fws_pkg

// *** core/fws_cyc_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// one flash bus cycle: request from sequencer, answer from engine
interface fws_cyc_if;
  logic req;
  logic wr;
  logic [fws_pkg::AW-1:0] addr;
  logic [fws_pkg::DW-1:0] wdata;
  logic [fws_pkg::DW-1:0] rdata;
  logic done;
  modport master (output req, wr, addr, wdata, input rdata, done);
  modport engine (input req, wr, addr, wdata, output rdata, done);
endinterface : fws_cyc_if
`default_nettype wire

// *** core/fws_cyc_engine.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// single read or write cycle on the flash pins
module fws_cyc_engine (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // sequencer side
  fws_cyc_if.engine cyc,
  // flash pins
  output logic [fws_pkg::AW-1:0] flash_addr,
  input wire logic [fws_pkg::DW-1:0] flash_dq_in,
  output logic [fws_pkg::DW-1:0] flash_dq_out,
  output logic flash_dq_oe_n,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  import fws_pkg::*;

  typedef enum logic [1:0] {E_IDLE, E_STROBE, E_RECOV} fws_eng_e;
  typedef struct packed {
    fws_eng_e state;
    logic [CW-1:0] cnt;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic done;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe_n;
  } fws_eng_s;

  fws_eng_s r_reg;
  fws_eng_s r_next;

  // ==========================================================
  // cycle sequencing
  always_comb
  begin
    r_next = r_reg;
    r_next.done = 1'b0;
    unique case (r_reg.state)
      E_IDLE:
        if (cyc.req)
        begin
          r_next.addr = cyc.addr;
          r_next.wdata = cyc.wdata;
          r_next.ce_n = 1'b0;
          r_next.we_n = !cyc.wr;
          r_next.oe_n = cyc.wr;
          r_next.dq_oe_n = !cyc.wr; // drive only on writes
          r_next.cnt = cyc.wr ? CW'(WP_CYC - 1) : CW'(ACC_CYC - 1);
          r_next.state = E_STROBE;
        end
      E_STROBE:
        if (r_reg.cnt == '0)
        begin
          r_next.rdata = flash_dq_in; // sample at end of access
          r_next.we_n = 1'b1;
          r_next.oe_n = 1'b1;
          r_next.state = E_RECOV;
        end
        else
          r_next.cnt = r_reg.cnt - 1'b1;
      E_RECOV:
      begin
        r_next.ce_n = 1'b1;
        r_next.dq_oe_n = 1'b1;
        r_next.done = 1'b1;
        r_next.state = E_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r_reg <= '0;
      r_reg.state <= E_IDLE;
      r_reg.ce_n <= 1'b1;
      r_reg.oe_n <= 1'b1;
      r_reg.we_n <= 1'b1;
      r_reg.dq_oe_n <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  // outputs straight from flops
  assign flash_addr = r_reg.addr;
  assign flash_dq_out = r_reg.wdata;
  assign flash_dq_oe_n = r_reg.dq_oe_n;
  assign flash_ce_n = r_reg.ce_n;
  assign flash_oe_n = r_reg.oe_n;
  assign flash_we_n = r_reg.we_n;
  assign cyc.rdata = r_reg.rdata;
  assign cyc.done = r_reg.done;

  // ==========================================================
  // checks on the pin cycle
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_strobe_excl: assert property (!(!flash_oe_n && !flash_we_n))
    else $error("read and write strobes low together");
  a_read_nodrive: assert property (!flash_oe_n |-> flash_dq_oe_n)
    else $error("data driven during a read");
  a_read_width: assert property ($fell(flash_oe_n) |->
    !flash_ce_n ##1 !flash_oe_n ##1 flash_oe_n ##1 cyc.done)
    else $error("read strobe width or answer wrong");
endmodule : fws_cyc_engine
`default_nettype wire

// *** core/fws_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// host sequencer: command writes, status polling, answers
module fws_host (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // user command
  input wire logic cmd_valid,
  input wire fws_pkg::fws_op_e cmd_op,
  input wire logic [fws_pkg::AW-1:0] cmd_addr,
  input wire logic [fws_pkg::DW-1:0] cmd_data,
  output logic cmd_ready,
  // user response
  output logic rsp_valid,
  output fws_pkg::fws_rsp_e rsp_code,
  output logic [fws_pkg::DW-1:0] rsp_data,
  output logic erase_window_open,
  output logic erase_suspended,
  // flash pins
  output logic [fws_pkg::AW-1:0] flash_addr,
  input wire logic [fws_pkg::DW-1:0] flash_dq_in,
  output logic [fws_pkg::DW-1:0] flash_dq_out,
  output logic flash_dq_oe_n,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  import fws_pkg::*;

  typedef enum logic [2:0] {
    M_IDLE, M_WRITE, M_READ, M_PRE, M_POST, M_POLL_A, M_POLL_B, M_RESET
  } fws_st_e;
  typedef struct packed {
    fws_st_e state;
    fws_op_e op;
    logic [AW-1:0] op_addr;
    logic [DW-1:0] op_data;
    logic [2:0] step;
    logic issued;
    logic req;
    logic wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] first;
    logic fail_seen;
    logic pre_ok;
    logic [DW-1:0] last_cmd;
    logic cmd_ready;
    logic rsp_valid;
    fws_rsp_e rsp_code;
    logic [DW-1:0] rsp_data;
    logic window_open;
    logic suspended;
  } fws_host_s;

  fws_host_s r_reg;
  fws_host_s r_next;
  fws_cyc_if cyc ();
  logic toggling;

  // ==========================================================
  // command sequence tables
  function automatic logic [2:0] seq_len(input fws_op_e op);
    unique case (op)
      OP_PROG: seq_len = SEQ_LEN_PROG;
      OP_SECT, OP_CHIP: seq_len = SEQ_LEN_ERASE;
      default: seq_len = SEQ_LEN_ONE;
    endcase
  endfunction : seq_len

  function automatic logic [AW+DW-1:0] seq_word(input fws_op_e op,
    input logic [2:0] step, input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic er;
    er = (op == OP_SECT);
    unique case (op)
      OP_ADD: seq_word = {a, CMD_SECT};
      OP_SUSPEND: seq_word = {a, CMD_SUSPEND};
      OP_RESUME: seq_word = {a, CMD_RESUME};
      OP_RESET: seq_word = {ADDR_UNLOCK1, CMD_RESET};
      default:
        unique case (step)
          3'h0, 3'h3: seq_word = (op == OP_PROG && step == 3'h3) ?
            {a, d} : {ADDR_UNLOCK1, CMD_UNLOCK1};
          3'h1, 3'h4: seq_word = {ADDR_UNLOCK2, CMD_UNLOCK2};
          3'h2: seq_word = {ADDR_UNLOCK1,
            (op == OP_PROG) ? CMD_PROG : CMD_ERASE};
          default: seq_word = er ? {a, CMD_SECT} : {ADDR_UNLOCK1, CMD_CHIP};
        endcase
    endcase
  endfunction : seq_word

  // busy bit changed between the two poll reads
  assign toggling = r_reg.first[BIT_TOG] ^ cyc.rdata[BIT_TOG];

  // ==========================================================
  // sequencer
  always_comb
  begin
    r_next = r_reg;
    r_next.req = 1'b0;
    r_next.rsp_valid = 1'b0;
    unique case (r_reg.state)
      M_IDLE:
        if (cmd_valid)
        begin
          r_next.op = cmd_op;
          r_next.op_addr = cmd_addr;
          r_next.op_data = cmd_data;
          r_next.step = 3'h0;
          r_next.fail_seen = 1'b0;
          r_next.pre_ok = 1'b0;
          r_next.cmd_ready = 1'b0;
          unique case (cmd_op)
            OP_READ: r_next.state = M_READ;
            OP_WAIT: r_next.state = M_POLL_A;
            OP_ADD: r_next.state = M_PRE;
            default: r_next.state = M_WRITE;
          endcase
        end
      M_WRITE:
        if (!r_reg.issued)
        begin
          {r_next.addr, r_next.wdata} = seq_word(r_reg.op, r_reg.step,
            r_reg.op_addr, r_reg.op_data);
          r_next.req = 1'b1;
          r_next.wr = 1'b1;
          r_next.issued = 1'b1;
          r_next.last_cmd = r_next.wdata;
        end
        else if (cyc.done)
        begin
          r_next.issued = 1'b0;
          r_next.step = r_reg.step + 3'h1;
          if (r_reg.step == seq_len(r_reg.op) - 3'h1)
          begin
            r_next.step = 3'h0;
            unique case (r_reg.op)
              OP_ADD: r_next.state = M_POST;
              OP_RESUME, OP_RESET:
              begin
                r_next.suspended = 1'b0;
                r_next.rsp_valid = 1'b1;
                r_next.rsp_code = RSP_OK;
                r_next.rsp_data = '0;
                r_next.cmd_ready = 1'b1;
                r_next.state = M_IDLE;
              end
              default: r_next.state = M_POLL_A;
            endcase
          end
        end
      M_READ, M_PRE, M_POST, M_POLL_A, M_POLL_B:
        if (!r_reg.issued)
        begin
          r_next.req = 1'b1;
          r_next.wr = 1'b0;
          r_next.addr = r_reg.op_addr;
          r_next.issued = 1'b1;
        end
        else if (cyc.done)
        begin
          r_next.issued = 1'b0;
          r_next.rsp_data = cyc.rdata;
          r_next.rsp_code = RSP_OK;
          r_next.rsp_valid = 1'b1;
          r_next.cmd_ready = 1'b1;
          r_next.state = M_IDLE;
          unique case (r_reg.state)
            M_PRE:
            begin
              r_next.window_open = !cyc.rdata[BIT_WIN];
              if (cyc.rdata[BIT_WIN])
                r_next.rsp_code = RSP_REJECT;
              else
              begin
                r_next.pre_ok = 1'b1;
                r_next.rsp_valid = 1'b0;
                r_next.cmd_ready = 1'b0;
                r_next.state = M_WRITE;
              end
            end
            M_POST:
            begin
              r_next.window_open = !cyc.rdata[BIT_WIN];
              if (cyc.rdata[BIT_WIN])
                r_next.rsp_code = RSP_REJECT;
            end
            M_POLL_A:
            begin
              r_next.first = cyc.rdata;
              r_next.rsp_valid = 1'b0;
              r_next.cmd_ready = 1'b0;
              r_next.state = M_POLL_B;
            end
            M_POLL_B:
              if (r_reg.op == OP_SECT)
                r_next.window_open = !cyc.rdata[BIT_WIN];
              else if (!toggling)
              begin
                if (r_reg.op == OP_SUSPEND)
                  r_next.suspended = 1'b1;
                else
                  r_next.window_open = 1'b0;
              end
              else
              begin
                r_next.rsp_valid = 1'b0;
                r_next.cmd_ready = 1'b0;
                r_next.fail_seen = cyc.rdata[BIT_FAIL];
                r_next.state = r_reg.fail_seen ? M_RESET : M_POLL_A;
              end
            default:
            begin
            end
          endcase
        end
      M_RESET:
        if (!r_reg.issued)
        begin
          r_next.addr = ADDR_UNLOCK1;
          r_next.wdata = CMD_RESET;
          r_next.last_cmd = CMD_RESET;
          r_next.req = 1'b1;
          r_next.wr = 1'b1;
          r_next.issued = 1'b1;
        end
        else if (cyc.done)
        begin
          r_next.issued = 1'b0;
          r_next.window_open = 1'b0;
          r_next.rsp_valid = 1'b1;
          r_next.rsp_code = RSP_FAIL;
          r_next.cmd_ready = 1'b1;
          r_next.state = M_IDLE;
        end
    endcase
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r_reg <= '0;
      r_reg.state <= M_IDLE;
      r_reg.cmd_ready <= 1'b1;
    end
    else
      r_reg <= r_next;
  end

  // link to the cycle engine
  assign cyc.req = r_reg.req;
  assign cyc.wr = r_reg.wr;
  assign cyc.addr = r_reg.addr;
  assign cyc.wdata = r_reg.wdata;

  // user outputs from flops
  assign cmd_ready = r_reg.cmd_ready;
  assign rsp_valid = r_reg.rsp_valid;
  assign rsp_code = r_reg.rsp_code;
  assign rsp_data = r_reg.rsp_data;
  assign erase_window_open = r_reg.window_open;
  assign erase_suspended = r_reg.suspended;

  fws_cyc_engine u_engine (
    .clk(clk),
    .rst(rst),
    .cyc(cyc),
    .flash_addr(flash_addr),
    .flash_dq_in(flash_dq_in),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe_n(flash_dq_oe_n),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n)
  );

  // ==========================================================
  // checks on the sequencer
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_fail_after_reset: assert property (rsp_valid && rsp_code == RSP_FAIL
    |-> r_reg.last_cmd == CMD_RESET)
    else $error("fail answered without reset command");
  a_add_pre_check: assert property (cyc.req && cyc.wr
    && r_reg.op == OP_ADD |-> r_reg.pre_ok)
    else $error("added sector written without window check");
  a_add_post_flag: assert property (rsp_valid && r_reg.op == OP_ADD
    && rsp_code == RSP_OK |-> !rsp_data[BIT_WIN])
    else $error("added sector accepted with window closed");
  a_sect_window: assert property (rsp_valid && r_reg.op == OP_SECT
    |-> erase_window_open == !rsp_data[BIT_WIN])
    else $error("window state does not match status read");
  a_poll_addr: assert property (cyc.req && !cyc.wr
    |-> cyc.addr == r_reg.op_addr)
    else $error("status read at wrong address");
  a_req_spacing: assert property (cyc.req |=> !cyc.req ##1 !cyc.req)
    else $error("bus requests too close");
  c_prog_ok: cover property (rsp_valid && r_reg.op == OP_PROG
    && rsp_code == RSP_OK);
  c_fail: cover property (rsp_valid && rsp_code == RSP_FAIL);
  c_add_reject: cover property (rsp_valid && rsp_code == RSP_REJECT);
  c_suspend: cover property ($rose(erase_suspended));
endmodule : fws_host
`default_nettype wire

// *** testbench/fws_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// behavioural flash device with embedded status reporting
module fws_flash_model #(
  parameter int PROG_CYC = 40,
  parameter int WIN_CYC = 100,
  parameter int ERASE_CYC = 600,
  parameter int LIMIT_CYC = 30
) (
  // clock
  input wire logic clk,
  // device pins
  input wire logic [fws_pkg::AW-1:0] flash_addr,
  input wire logic [fws_pkg::DW-1:0] dq_wire,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  output logic [fws_pkg::DW-1:0] dev_dq
);
  import fws_pkg::*;
  logic [DW-1:0] mem [0:(2**AW)-1];
  logic [DW-1:0] pd = 8'h00;
  logic [DW-1:0] last = 8'h00;
  logic [DW-1:0] cur;
  logic [3:0] sel = 4'h0;
  logic tog = 1'b0;
  logic stog = 1'b0;
  logic oe_q = 1'b1;
  // md: 0 array, 1 program, 2 failed, 3 window, 4 erase, 5 suspend
  int md = 0;
  int stage = 0;
  int tmr = 0;
  int pa = 0;
  wire [1:0] sec = flash_addr[AW-1:AW-2];
  wire [DW-1:0] d = dq_wire;
  wire rd = !flash_ce_n && !flash_oe_n && oe_q;
  wire wr = !flash_ce_n && !flash_we_n;
  initial
    foreach (mem[i]) mem[i] = 8'hff;
  // status or array data for the addressed location
  always_comb
  begin
    cur = mem[flash_addr];
    if (md == 1 || md == 2)
      cur = {~pd[7], tog, md == 2 && tmr >= LIMIT_CYC, 2'h0, stog, 2'h0};
    else if (md == 3 || md == 4)
      cur = {1'b0, tog, 2'h0, md == 4, stog, 2'h0};
    else if (md == 5 && sel[sec])
      cur = {1'b1, tog, 2'h0, 1'b0, stog, 2'h0};
  end
  // released bus shows the inverse of the last value
  assign dev_dq = (!flash_ce_n && !flash_oe_n) ? cur : ~last;
  // read toggles, timers and command decode
  always @(posedge clk)
  begin
    oe_q <= flash_oe_n;
    if (!flash_ce_n && !flash_oe_n)
      last <= cur;
    if (rd && md != 0 && md != 5)
      tog <= ~tog;
    if (rd && md != 0 && sel[sec])
      stog <= ~stog;
    if (md == 2)
      tmr <= tmr + 1;
    else if (md != 0 && md != 5 && tmr > 1)
      tmr <= tmr - 1;
    else if (md == 1)
    begin
      mem[pa] <= mem[pa] & pd;
      md <= 0;
    end
    else if (md == 3)
    begin
      md <= 4;
      tmr <= ERASE_CYC;
    end
    else if (md == 4)
    begin
      for (int i = 0; i < 2**AW; i++)
        if (sel[i >> (AW - 2)])
          mem[i] <= 8'hff;
      sel <= 4'h0;
      md <= 0;
    end
    if (wr && md == 4 && d == CMD_SUSPEND)
      md <= 5;
    else if (wr && md == 5 && d == CMD_RESUME)
      md <= 4;
    else if (wr && md == 2 && d == CMD_RESET)
      md <= 0;
    else if (wr && md == 3 && d == CMD_SECT)
    begin
      sel[sec] <= 1'b1;
      tmr <= WIN_CYC;
    end
    else if (wr && md == 0)
    begin
      stage <= 0;
      if (stage == 0 && flash_addr == ADDR_UNLOCK1 && d == CMD_UNLOCK1)
        stage <= 1;
      if (stage == 1 && flash_addr == ADDR_UNLOCK2 && d == CMD_UNLOCK2)
        stage <= 2;
      if (stage == 2)
        stage <= (d == CMD_PROG) ? 6 : (d == CMD_ERASE) ? 3 : 0;
      if (stage == 3 && d == CMD_UNLOCK1)
        stage <= 4;
      if (stage == 4 && d == CMD_UNLOCK2)
        stage <= 5;
      if (stage == 5 && (d == CMD_SECT || d == CMD_CHIP))
      begin
        md <= (d == CMD_SECT) ? 3 : 4;
        sel <= (d == CMD_SECT) ? 4'h1 << sec : 4'hf;
        tmr <= (d == CMD_SECT) ? WIN_CYC : ERASE_CYC;
      end
      if (stage == 6)
      begin
        pa <= int'(flash_addr);
        pd <= d;
        md <= ((d & ~mem[flash_addr]) != 8'h00) ? 2 : 1;
        tmr <= ((d & ~mem[flash_addr]) != 8'h00) ? 0 : PROG_CYC;
      end
    end
  end
endmodule : fws_flash_model
`default_nettype wire

// *** testbench/flash_write_status_reporting_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench: host sequencer against the flash model
module flash_write_status_reporting_tb;
  import fws_pkg::*;
  localparam int S1 = 32'h0000_8000;
  localparam int S2 = 32'h0001_0000;
  localparam int S3 = 32'h0001_8000;
  logic clk = 1'b0;
  logic rst, cmd_valid, cmd_ready, rsp_valid;
  fws_op_e cmd_op;
  fws_rsp_e rsp_code;
  logic [AW-1:0] cmd_addr, flash_addr;
  logic [DW-1:0] cmd_data, rsp_data, flash_dq_in, flash_dq_out, dev_dq;
  logic erase_window_open, erase_suspended;
  logic flash_dq_oe_n, flash_ce_n, flash_oe_n, flash_we_n;
  logic [31:0] seed = 32'h0001_2671;
  int mismatches = 0;
  int checks_done = 0;
  int ref_mem [0:131071];
  int a, d;
  // wire level of the shared data pins
  assign flash_dq_in = flash_dq_oe_n ? dev_dq : flash_dq_out;
  fws_host dut (.clk, .rst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data,
    .cmd_ready, .rsp_valid, .rsp_code, .rsp_data, .erase_window_open,
    .erase_suspended, .flash_addr, .flash_dq_in, .flash_dq_out,
    .flash_dq_oe_n, .flash_ce_n, .flash_oe_n, .flash_we_n);
  fws_flash_model flash (.clk, .flash_addr, .dq_wire(flash_dq_in),
    .flash_ce_n, .flash_oe_n, .flash_we_n, .dev_dq);
  // clock
  initial
    forever #20 clk = ~clk;
  // watchdog
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    results();
  end
  // ==========================================================
  // helpers
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return int'(seed);
  endfunction : xs
  task automatic results();
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  task automatic chk_code(fws_rsp_e got, fws_rsp_e exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: code %0d not %0d", $time, got, exp);
    end
  endtask : chk_code
  task automatic chk_data(logic [7:0] got, logic [7:0] exp, logic [7:0] m);
    checks_done++;
    if ((got & m) !== (exp & m))
    begin
      mismatches++;
      $display("wrong value at %0t: data %h not %h", $time, got, exp);
    end
  endtask : chk_data
  task automatic chk_flag(logic got, logic exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: flag %b not %b", $time, got, exp);
    end
  endtask : chk_flag
  // one user command, driven at falling edges
  task automatic exec(fws_op_e op, int ad, int dt, fws_rsp_e exp);
    int n;
    n = 0;
    @(negedge clk);
    while (cmd_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = ad[AW-1:0];
    cmd_data = dt[DW-1:0];
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 8000)
    begin
      @(negedge clk);
      n++;
    end
    chk_flag(rsp_valid, 1'b1);
    chk_code(rsp_code, exp);
  endtask : exec
  task automatic prog(int ad, int dt);
    logic fail;
    fail = (dt & ~ref_mem[ad] & 255) != 0;
    exec(OP_PROG, ad, dt, fail ? RSP_FAIL : RSP_OK);
    if (!fail)
      ref_mem[ad] = ref_mem[ad] & dt;
  endtask : prog
  task automatic rd(int ad);
    exec(OP_READ, ad, xs(), RSP_OK);
    chk_data(rsp_data, ref_mem[ad][7:0], 8'hff);
  endtask : rd
  task automatic ers(logic [3:0] m);
    for (int i = 0; i < 131072; i++)
      if (m[i >> 15])
        ref_mem[i] = 255;
  endtask : ers
  // ==========================================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_READ;
    cmd_addr = '0;
    cmd_data = '0;
    for (int i = 0; i < 131072; i++)
      ref_mem[i] = 255;
    repeat (8) @(negedge clk);
    chk_flag(flash_ce_n & flash_oe_n & flash_we_n & flash_dq_oe_n, 1'b1);
    chk_flag(cmd_ready, 1'b1);
    rst = 1'b0;
    // random bytes programmed in sector 0, then one over a zero
    for (int i = 0; i < 4; i++)
    begin
      a = xs() & 32'h0000_7fff;
      d = xs() & 32'h0000_007f;
      prog(a, d);
      rd(a);
    end
    prog(a, 32'h0000_0080);
    rd(a);
    // sector erase with two added sectors late in the window
    prog(S1, 32'h0000_0000);
    exec(OP_SECT, S1, xs(), RSP_OK);
    chk_flag(erase_window_open, 1'b1);
    repeat (40) @(negedge clk);
    exec(OP_ADD, S2, xs(), RSP_OK);
    repeat (50) @(negedge clk);
    exec(OP_ADD, S3, xs(), RSP_OK);
    exec(OP_WAIT, S1, xs(), RSP_OK);
    chk_flag(erase_window_open, 1'b0);
    ers(4'he);
    rd(S1);
    rd(a);
    // late add refused, suspend and resume
    prog(S2, 32'h0000_005a);
    exec(OP_SECT, S1, xs(), RSP_OK);
    repeat (120) @(negedge clk);
    exec(OP_READ, S1, xs(), RSP_OK);
    chk_data(rsp_data, 8'h08, 8'ha8);
    exec(OP_ADD, S2, xs(), RSP_REJECT);
    chk_flag(erase_window_open, 1'b0);
    exec(OP_SUSPEND, S1, xs(), RSP_OK);
    chk_flag(erase_suspended, 1'b1);
    rd(a);
    exec(OP_READ, S1, xs(), RSP_OK);
    chk_data(rsp_data, 8'h80, 8'ha0);
    exec(OP_RESUME, S1, xs(), RSP_OK);
    chk_flag(erase_suspended, 1'b0);
    exec(OP_WAIT, S1, xs(), RSP_OK);
    ers(4'h2);
    rd(S1);
    rd(S2);
    // whole-chip erase runs with no window
    exec(OP_CHIP, S3, xs(), RSP_OK);
    ers(4'hf);
    rd(a);
    rd(S2);
    exec(OP_RESET, 0, xs(), RSP_OK);
    results();
  end
endmodule : flash_write_status_reporting_tb
`default_nettype wire
